/* File: hw/lpg_pkg.sv */
// Purpose : shared constants and carriers for the table pointer generator
// Assumes : 16-bit table words, 256-word table memory, 12-bit samples
// Notes   : register indices are word indices on the plain register port
package lpg_pkg;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_SETUP0   = 4'h0;  // first of four setups
    localparam logic [3:0] IDX_SRC_SEL  = 4'h4;  // pointer source per setup
    localparam logic [3:0] IDX_TBL_ADDR = 4'h5;  // table access address
    localparam logic [3:0] IDX_TBL_DATA = 4'h6;  // table access data window
    localparam logic [3:0] IDX_STATUS   = 4'h7;  // busy and last setup used
    localparam logic [3:0] IDX_RESULT   = 4'h8;  // last computed value

    // ------------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [3:0]  SRC_RESET   = 4'h0;
    localparam int          POINTER_OFFSET_LSB    = 10;
    localparam int          INTD_LSB    = 8;
    localparam int          POINTER_WIDTH_SEL_LSB   = 6;
    localparam int          TABLE_LENGTH_SEL_LSB   = 3;
    localparam int          SOT_LSB     = 0;

    // ------------------------------------------------------------------
    // arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [2:0] BASE_SHIFT   = 3'h7;  // shift before settings
    localparam int         START_SHIFT  = 5;     // start code to address
    localparam int         TABLE_STEP   = 32;    // locations per size code
    localparam int         CHANNELS     = 4;     // independent setups

    // setup word, msb first as stored
    typedef struct packed {
        logic [5:0] pointerOffset;
        logic [1:0] interpDegree;
        logic [1:0] pointerWidthSel;
        logic [2:0] tableLengthSel;
        logic [2:0] tableStartSel;
    } lpg_setup_s;

    // lookup request
    typedef struct packed {
        logic [1:0]  channel;
        logic [11:0] adcSample;
        logic [11:0] powerCtrlComp;
    } lpg_req_s;

    // lookup answer
    typedef struct packed {
        logic [15:0] value;
        logic [7:0]  lowerEntryAddr;
        logic [7:0]  upperEntryAddr;
    } lpg_res_s;

    typedef enum {
        ST_IDLE,
        ST_FETCH_LO,
        ST_FETCH_HI,
        ST_WAIT_HI,
        ST_COMBINE
    } lpg_state_e;

endpackage

/* File: hw/lpg_pointer_gen.sv */
// Purpose : turns a sample into table addresses and a compensation value
// Assumes : one lookup at a time; table held in a local word store
// Notes   : result answers four cycles after acceptance when unstalled
//
// Behaviour
// - raw pointer is sample shifted right variably
// - pointer is fixed point with fractional bits
// - width code picks five to eight integer bits
// - offset shifted left zero, one or two
// - offset is signed, sign kept throughout
// - offset range scales with width code
// - shifted offset added to raw pointer
// - clamp negative to zero, high to last
// - address is start code times 32 plus pointer
// - degree zero returns the addressed word
// - otherwise interpolate between two adjacent words
// - degree code gives zero to three fraction bits
// - setup word field layout, all reset zero
// - length codes 1 to 6 select 32 to 192 locations; 7 selects 224
// - start codes 2 to 7 map to 0x40 through 0xE0; 0 and 1 map to 0x00 and 0x20
// - pointer source is sample or power parameter
// - four independent setups, tables may be shared
// - pointer wider than table is clamped
`timescale 1ns/100ps
module lpg_pointer_gen (
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic [3:0]      regAddr,
    input  wire logic [15:0]     regWdata,
    input  wire logic            regWrite,
    input  wire logic            regRead,
    output logic      [15:0]     regRdata,
    input  wire logic            reqValid,
    input  wire lpg_pkg::lpg_req_s req,
    output logic                 reqReady,
    output logic                 resValid,
    output lpg_pkg::lpg_res_s    res
);
    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    lpg_pkg::lpg_setup_s setup [lpg_pkg::CHANNELS];  // per channel setup
    logic [3:0]          srcSel;        // 1 selects the power parameter
    logic [7:0]          tblAddr;       // software table address
    logic [15:0]         tblReadback;   // word at tblAddr, refreshed
    logic                prefetchReq;   // refresh tblReadback next cycle
    logic                prefetchPend;  // prefetch read in flight
    logic [1:0]          lastChannel;   // setup used by last lookup
    logic                busy;          // lookup in progress
    logic isSetup;
    assign isSetup = (regAddr < lpg_pkg::CHANNELS);
    // setup words, one per channel; shared start codes share a table
    genvar g;
    generate
        for (g = 0; g < lpg_pkg::CHANNELS; g++) begin : gSetup
            always_ff @(posedge clock) begin
                if (rst) begin
                    setup[g] <= lpg_pkg::SETUP_RESET;
                end else if (regWrite && regAddr == 4'(g)) begin
                    setup[g] <= regWdata;
                end
            end
        end
    endgenerate

    // pointer source select
    always_ff @(posedge clock) begin
        if (rst) begin
            srcSel <= lpg_pkg::SRC_RESET;
        end else if (regWrite && regAddr == lpg_pkg::IDX_SRC_SEL) begin
            srcSel <= regWdata[3:0];
        end
    end

    // table address: set by software, steps after each data write
    always_ff @(posedge clock) begin
        if (rst) begin
            tblAddr <= 8'h00;
        end else if (regWrite && regAddr == lpg_pkg::IDX_TBL_ADDR) begin
            tblAddr <= regWdata[7:0];
        end else if (regWrite && regAddr == lpg_pkg::IDX_TBL_DATA) begin
            tblAddr <= tblAddr + 8'h01;
        end
    end

    // readback refresh; it takes the port ahead of lookup fetches,
    // so each table address or data write can stall a lookup by one cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            prefetchReq  <= 1'b0;
            prefetchPend <= 1'b0;
        end else begin
            prefetchReq  <= regWrite && (regAddr == lpg_pkg::IDX_TBL_ADDR ||
                                         regAddr == lpg_pkg::IDX_TBL_DATA);
            prefetchPend <= prefetchReq;
        end
    end

    // ------------------------------------------------------------------
    // register read port: data only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdata <= 16'h0000;
        end else if (!regRead) begin
            regRdata <= 16'h0000;
        end else if (isSetup) begin
            regRdata <= setup[regAddr[1:0]];
        end else begin
            unique case (regAddr)
                lpg_pkg::IDX_SRC_SEL:  regRdata <= {12'h000, srcSel};
                lpg_pkg::IDX_TBL_ADDR: regRdata <= {8'h00, tblAddr};
                lpg_pkg::IDX_TBL_DATA: regRdata <= tblReadback;
                lpg_pkg::IDX_STATUS:   regRdata <= {13'h0000, busy,
                                                    lastChannel};
                lpg_pkg::IDX_RESULT:   regRdata <= res.value;
                default:               regRdata <= 16'h0000; // unmapped
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pointer arithmetic for the request being offered
    // ------------------------------------------------------------------
    lpg_pkg::lpg_setup_s cfg;
    logic [11:0]        sample;
    logic [2:0]         rShift;
    logic signed [13:0] rawPtr;
    logic [2:0]         offShift;
    logic signed [13:0] offExt;
    logic signed [13:0] sumPtr;
    logic [8:0]         tableLen;
    logic signed [13:0] limitPtr;
    logic signed [13:0] clampPtr;
    logic [7:0]         intPart;
    logic [2:0]         fracPart;
    logic [7:0]         startBase;
    always_comb begin
        cfg      = setup[req.channel];
        sample   = srcSel[req.channel] ? req.powerCtrlComp
                                       : req.adcSample;
        // integer width code plus fraction count lowers the shift
        rShift   = lpg_pkg::BASE_SHIFT - {1'b0, cfg.pointerWidthSel}
                                       - {1'b0, cfg.interpDegree};
        rawPtr   = $signed({2'b00, sample} >> rShift);
        // offset scale per width code, then aligned to the fraction point
        unique case (cfg.pointerWidthSel)
            2'h2:    offShift = 3'h1;
            2'h3:    offShift = 3'h2;
            default: offShift = 3'h0;
        endcase
        offExt   = {{8{cfg.pointerOffset[5]}}, cfg.pointerOffset};
        offExt   = offExt <<< (offShift + {1'b0, cfg.interpDegree});
        sumPtr   = rawPtr + offExt;
        // unused length codes: 000 behaves as the smallest table
        tableLen = (cfg.tableLengthSel == 3'h0) ? 9'(lpg_pkg::TABLE_STEP)
                 : 9'(cfg.tableLengthSel * lpg_pkg::TABLE_STEP);
        limitPtr = $signed({5'h00, 9'(tableLen - 9'h001)})
                   <<< cfg.interpDegree;
        if (sumPtr < 0) begin
            clampPtr = 14'sh0000;
        end else if (sumPtr > limitPtr) begin
            clampPtr = limitPtr;
        end else begin
            clampPtr = sumPtr;
        end
        intPart   = 8'(clampPtr >>> cfg.interpDegree);
        fracPart  = 3'(clampPtr) & 3'((4'h1 << cfg.interpDegree) - 4'h1);
        startBase = {cfg.tableStartSel, 5'h00};
    end

    // ------------------------------------------------------------------
    // lookup sequencer
    // ------------------------------------------------------------------
    lpg_pkg::lpg_state_e state;
    logic [7:0]  loAddr;       // lower entry address
    logic [7:0]  hiAddr;       // upper entry address
    logic [2:0]  curFrac;      // fractional distance in eighths or less
    logic [1:0]  curDegree;    // fraction bit count of this lookup
    logic [15:0] loValue;      // lower entry word
    logic [15:0] hiValue;      // upper entry word
    logic        fsmRdEn;
    logic [7:0]  fsmRdAddr;
    logic        rdPendLo;
    logic        rdPendHi;
    logic        accept;
    logic [15:0] memQ;
    assign accept    = (state == lpg_pkg::ST_IDLE) && reqValid;
    // a pending readback refresh takes the port for one cycle
    assign fsmRdEn   = !prefetchReq &&
                       (state == lpg_pkg::ST_FETCH_LO ||
                        state == lpg_pkg::ST_FETCH_HI);
    assign fsmRdAddr = prefetchReq ? tblAddr :
                       (state == lpg_pkg::ST_FETCH_HI) ? hiAddr : loAddr;

    // state transitions
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= lpg_pkg::ST_IDLE;
        end else begin
            unique case (state)
                lpg_pkg::ST_IDLE:     if (accept) begin
                    state <= lpg_pkg::ST_FETCH_LO;
                end
                lpg_pkg::ST_FETCH_LO: if (fsmRdEn) begin
                    state <= lpg_pkg::ST_FETCH_HI;
                end
                lpg_pkg::ST_FETCH_HI: if (fsmRdEn) begin
                    state <= lpg_pkg::ST_WAIT_HI;
                end
                lpg_pkg::ST_WAIT_HI:  state <= lpg_pkg::ST_COMBINE;
                lpg_pkg::ST_COMBINE:  state <= lpg_pkg::ST_IDLE;
            endcase
        end
    end

    // latch addresses at acceptance so setup writes cannot disturb them
    always_ff @(posedge clock) begin
        if (rst) begin
            loAddr      <= 8'h00;
            hiAddr      <= 8'h00;
            curFrac     <= 3'h0;
            curDegree   <= 2'h0;
            lastChannel <= 2'h0;
        end else if (accept) begin
            loAddr      <= startBase + intPart;
            // degree zero reads the same word twice, keeping one timing
            hiAddr      <= (cfg.interpDegree == 2'h0) ? startBase + intPart
                         : startBase + intPart + 8'h01;
            curFrac     <= fracPart;
            curDegree   <= cfg.interpDegree;
            lastChannel <= req.channel;
        end
    end

    // capture the words as they leave the table store
    always_ff @(posedge clock) begin
        if (rst) begin
            rdPendLo    <= 1'b0;
            rdPendHi    <= 1'b0;
            loValue     <= 16'h0000;
            hiValue     <= 16'h0000;
            tblReadback <= 16'h0000;
        end else begin
            rdPendLo <= fsmRdEn && state == lpg_pkg::ST_FETCH_LO;
            rdPendHi <= fsmRdEn && state == lpg_pkg::ST_FETCH_HI;
            if (rdPendLo) begin
                loValue <= memQ;
            end
            if (rdPendHi) begin
                hiValue <= memQ;
            end
            if (prefetchPend) begin
                tblReadback <= memQ;
            end
        end
    end

    lpg_table_mem #(
        .WIDTH (16),
        .DEPTH (256),
        .AW    (8)
    ) uTable (
        .clock  (clock),
        .wrEn   (regWrite && regAddr == lpg_pkg::IDX_TBL_DATA),
        .wrAddr (tblAddr),
        .wrData (regWdata),
        .rdEn   (fsmRdEn || prefetchReq),
        .rdAddr (fsmRdAddr),
        .rdData (memQ)
    );

    // ------------------------------------------------------------------
    // interpolation and answer
    // ------------------------------------------------------------------
    logic signed [16:0] diff;
    logic signed [20:0] weighted;
    logic signed [20:0] scaled;
    logic [15:0]        next_value;
    always_comb begin
        diff     = $signed({hiValue[15], hiValue})
                 - $signed({loValue[15], loValue});
        weighted = 21'(diff * $signed({1'b0, curFrac}));
        // bias negative products so the shift truncates toward zero
        if (weighted < 0) begin
            weighted = weighted
                     + $signed(21'((5'h01 << curDegree) - 5'h01));
        end
        scaled   = weighted >>> curDegree;
        if (curDegree == 2'h0) begin
            next_value = loValue;
        end else begin
            next_value = loValue + 16'(scaled);
        end
    end

    // answer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            resValid <= 1'b0;
            res      <= '0;
        end else begin
            resValid <= (state == lpg_pkg::ST_COMBINE);
            if (state == lpg_pkg::ST_COMBINE) begin
                res.value          <= next_value;
                res.lowerEntryAddr <= loAddr;
                res.upperEntryAddr <= hiAddr;
            end
        end
    end

    // ready and busy follow the sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            reqReady <= 1'b0;
            busy     <= 1'b0;
        end else begin
            reqReady <= !accept && (state == lpg_pkg::ST_IDLE ||
                                    state == lpg_pkg::ST_COMBINE);
            busy     <= accept || (state != lpg_pkg::ST_IDLE &&
                                   state != lpg_pkg::ST_COMBINE);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_answer_latency: assert property (accept |-> ##[4:64] resValid)
        else $error("lookup answer missing");
    a_exact_word: assert property (resValid && curDegree == 2'h0 |->
        res.value == loValue && res.lowerEntryAddr == res.upperEntryAddr)
        else $error("direct lookup not the addressed word");
    a_upper_adjacent: assert property (resValid && curDegree != 2'h0 |->
        res.upperEntryAddr == 8'(res.lowerEntryAddr + 8'h01))
        else $error("upper entry not adjacent");
    a_interp_between: assert property (resValid && curDegree != 2'h0 |->
        ($signed(res.value) >= $signed(loValue) ||
         $signed(res.value) >= $signed(hiValue)) &&
        ($signed(res.value) <= $signed(loValue) ||
         $signed(res.value) <= $signed(hiValue)))
        else $error("interpolated value outside entries");
    a_clamp_low: assert property (accept && sumPtr < 0 |=>
        loAddr == $past(startBase) && curFrac == 3'h0)
        else $error("negative pointer not clamped to zero");
    a_clamp_high: assert property (accept |=>
        8'(loAddr - $past(startBase)) <= 8'($past(tableLen) - 9'h001))
        else $error("pointer beyond table end");
    a_frac_width: assert property (accept |=>
        (curFrac >> curDegree) == 3'h0)
        else $error("fraction wider than degree");
    a_raw_shift: assert property (accept && sumPtr <= limitPtr &&
        cfg.pointerOffset == 6'h00 |=>
        ({3'h0, 8'(loAddr - $past(startBase))} << curDegree) +
        11'(curFrac) == 11'($past(sample) >> $past(rShift)))
        else $error("raw pointer shift wrong");
    a_read_slot: assert property (!$past(regRead) |-> regRdata == 16'h0000)
        else $error("read data outside its slot");
    a_setup_back: assert property (regWrite && isSetup ##1
        regRead && regAddr == $past(regAddr) |=>
        regRdata == $past(regWdata, 2))
        else $error("setup word readback differs");
    c_interp:    cover property (resValid && curDegree == 2'h3);
    c_clamp_low: cover property (accept && sumPtr < 0);
    c_clamp_hi:  cover property (accept && sumPtr > limitPtr);
    c_stalled:   cover property (prefetchReq && state == lpg_pkg::ST_FETCH_HI);

endmodule

/* File: hw/lpg_table_mem.sv */
// Purpose : word table store with one write and one registered read port
// Assumes : read and write of one address in one cycle reads the old word
// Notes   : contents are not reset; software loads them before use
`timescale 1ns/100ps
module lpg_table_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic             clock,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             rdEn,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] words [DEPTH];   // table words

    // write port
    always_ff @(posedge clock) begin
        if (wrEn) begin
            words[wrAddr] <= wrData;
        end
    end

    // read port holds its word until the next read
    always_ff @(posedge clock) begin
        if (rdEn) begin
            rdData <= words[rdAddr];
        end
    end

endmodule

/* File: test/lpg_pointer_gen_tb_top.sv */
// Purpose : self-checking bench for the table pointer generator
// Assumes : table loaded through the data window before any lookup
// Notes   : channels 1 and 3 take the power parameter as source
`timescale 1ns/100ps
module lpg_pointer_gen_tb_top;
    typedef struct packed {
        logic [15:0] setup;    // setup word
        logic [11:0] sample;   // pointer source value
        logic [7:0]  lowAddr;  // expected lower entry address
    } lpg_row_s;

    logic              clock, rst, regWrite, regRead, reqValid, reqReady;
    logic              resValid, taken;
    logic [3:0]        regAddr;
    logic [15:0]       regWdata, regRdata, rd;
    lpg_pkg::lpg_req_s req, r;
    lpg_pkg::lpg_res_s res, ex;
    int                n_errors, samples_checked, i, n;
    lpg_row_s          rows [7] = '{
        '{16'h200A, 12'h495, 8'h51}, '{16'hA2A4, 12'hE6A, 8'hC3},
        '{16'h0153, 12'h7FF, 8'h7F}, '{16'h83DF, 12'h010, 8'hE0},
        '{16'h7C75, 12'hFFF, 8'hFE}, '{16'h00CE, 12'hFFF, 8'hDF},
        '{16'h026A, 12'h9AB, 8'h66}};

    lpg_pointer_gen i_lpg_pointer_gen (.clock(clock), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .resValid(resValid), .res(res));
    lpg_req_source i_lpg_req_source (.clock(clock), .reqReady(reqReady),
        .reqValid(reqValid), .req(req));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // falling table contents make the entry difference negative
    function automatic int tv(input int a);
        return 16'hFFFF - a * a;
    endfunction

    // reference lookup worked out from the setup fields
    function automatic lpg_pkg::lpg_res_s model(input logic [15:0] s,
                                                input logic [11:0] x);
        lpg_pkg::lpg_setup_s c;
        lpg_pkg::lpg_res_s   o;
        int w, d, p, off, top, lo, hi;
        c   = s;
        w   = c.pointerWidthSel;
        d   = c.interpDegree;
        p   = x >> (7 - w - d);
        off = $signed(c.pointerOffset);
        off = off * (w == 3 ? 4 : w == 2 ? 2 : 1);
        p   = p + off * (1 << d);
        top = (c.tableLengthSel * 32 - 1) << d;
        if (p < 0) p = 0;
        if (p > top) p = top;
        lo  = c.tableStartSel * 32 + (p >> d);
        hi  = (d == 0) ? lo : lo + 1;
        o.lowerEntryAddr = 8'(lo);
        o.upperEntryAddr = 8'(hi);
        // weighted difference truncated toward zero
        o.value = 16'(tv(lo) + (p % (1 << d)) * (tv(hi) - tv(lo)) / (1 << d));
        return o;
    endfunction

    // one compare for every kind of result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // single-cycle write strobe
    task automatic busWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    // single-cycle read strobe; data stand only in the next cycle
    task automatic busRead(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        d = regRdata;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // clock, watchdog, main sequence
    // -----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // the whole run needs under seven hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {rst, regWrite, regRead, regAddr, regWdata} = {1'b1, 22'h0};
        n_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // setups and source select come out of reset cleared
        for (i = 0; i < 5; i++) begin
            busRead(4'(i), rd);
            chk(rd, 16'h0000);
        end
        busWrite(lpg_pkg::IDX_TBL_ADDR, 16'h0000);
        for (i = 0; i < 256; i++) busWrite(lpg_pkg::IDX_TBL_DATA, 16'(tv(i)));
        busWrite(lpg_pkg::IDX_SRC_SEL, 16'h000A);
        for (i = 0; i < 7; i++) begin
            busWrite(4'(i % 4), rows[i].setup);
            ex = model(rows[i].setup, rows[i].sample);
            r.channel       = 2'(i % 4);
            r.adcSample     = i[0] ? ~rows[i].sample : rows[i].sample;
            r.powerCtrlComp = i[0] ? rows[i].sample : ~rows[i].sample;
            i_lpg_req_source.issue(r, taken);
            n = 0;
            while (n < 64 && resValid !== 1'b1) begin
                @(posedge clock);
                #1;
                n++;
            end
            chk(16'(n), 16'h0004);
            chk(res.lowerEntryAddr, rows[i].lowAddr);
            chk(res.upperEntryAddr, ex.upperEntryAddr);
            chk(res.value, ex.value);
        end
        // hand tests: readback, result copy, unmapped place
        busRead(4'h2, rd);
        chk(rd, rows[6].setup);
        busRead(lpg_pkg::IDX_RESULT, rd);
        chk(rd, ex.value);
        busRead(lpg_pkg::IDX_STATUS, rd);
        chk(rd, 16'h0002);
        // write then read a setup with no gap between the strobes
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr  <= 4'h1;
        regWdata <= 16'h5A3C;
        @(posedge clock);
        regWrite <= 1'b0;
        regRead  <= 1'b1;
        @(posedge clock);
        regRead  <= 1'b0;
        @(negedge clock);
        chk(regRdata, 16'h5A3C);
        busRead(4'h9, rd);
        chk(rd, 16'h0000);
        busWrite(lpg_pkg::IDX_TBL_ADDR, 16'h0040);
        repeat (2) @(posedge clock);
        busRead(lpg_pkg::IDX_TBL_DATA, rd);
        chk(rd, 16'(tv(64)));
        // reset in mid-run clears the setups again
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        busRead(4'h1, rd);
        chk(rd, 16'h0000);
        tally_and_finish();
    end
endmodule

/* File: test/lpg_req_source.sv */
// Purpose : request source where samples and parameters arrive
// Assumes : one lookup in flight; reqReady high at an edge marks a take
// Notes   : released request lines show the inverse of the last value
`timescale 1ns/100ps
module lpg_req_source (
    input  wire logic         clock,
    input  wire logic         reqReady,
    output logic              reqValid,
    output lpg_pkg::lpg_req_s req
);
    // -----------------------------------------------------------------
    // idle at time zero
    // -----------------------------------------------------------------
    initial begin
        reqValid = 1'b0;
        req      = '0;
    end

    // hold the request until the edge that takes it, then release
    task automatic issue(input lpg_pkg::lpg_req_s r, output logic taken);
        int n;
        taken = 1'b0;
        @(posedge clock);
        reqValid <= 1'b1;
        req      <= r;
        for (n = 0; n < 64 && !taken; n++) begin
            @(posedge clock);
            taken = (reqReady === 1'b1);
        end
        reqValid <= 1'b0;
        // no stale sample left behind on released lines
        req      <= ~r;
    endtask
endmodule
